// ### pkg/usr_pkg.sv
// package: register map, field positions and timing constants of the serial receive block
package usr_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_RX_CTRL   = 8'h18;
   localparam logic [7:0] OFF_RX_DATA   = 8'h1a;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h1c;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h1d;
   localparam logic [7:0] OFF_TX_CTRL   = 8'h98;
   localparam logic [7:0] OFF_DIVISOR   = 8'h99;
   // ----------------------------------------
   // receive_status_control fields
   // ----------------------------------------
   localparam int B_SERIAL_PORT_ENABLE  = 7;
   localparam int B_NINE  = 6;
   localparam int B_SINGLE_RECEIVE_ENABLE  = 5;
   localparam int B_CONTINUOUS_RECEIVE_ENABLE  = 4;
   localparam int B_FRAMING_ERROR_FLAG  = 2;
   localparam int B_OVERRUN_ERROR_FLAG  = 1;
   localparam int B_NINTH = 0;
   // ----------------------------------------
   // transmit_status_control fields
   // ----------------------------------------
   localparam int B_CSRC  = 7;
   localparam int B_SYNC  = 4;
   localparam int B_HIGH  = 2;
   localparam int B_TRMT  = 1;
   // ----------------------------------------
   // interrupt status bits
   // ----------------------------------------
   localparam int I_BYTE  = 0;
   localparam int I_FRAME = 1;
   localparam int I_OVER  = 2;
   // ----------------------------------------
   // reset values and counts
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [1:0] PRE_ASYNC_LO = 2'h3;
   localparam logic [1:0] PRE_ASYNC_HI = 2'h0;
   localparam logic [1:0] PRE_SYNC     = 2'h1;
   localparam logic [3:0] SAMPLE_AT    = 4'h9;
   localparam logic [3:0] LAST_BIT_8   = 4'h7;
   localparam logic [3:0] LAST_BIT_9   = 4'h8;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } usr_rx_state_t;
endpackage

// ### logic/usr_maj_sampler.sv
// majority-of-three sampler for the receive line
`timescale 1ns/1ps
module usr_maj_sampler (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // sample strobe and line level
   input  wire logic en,
   input  wire logic d,
   // decided level
   output logic      maj_r
);
   logic [1:0] smp_r;
   wire        maj_nxt = (d & smp_r[0]) | (d & smp_r[1]) | (smp_r[0] & smp_r[1]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         smp_r <= 2'h3;
         maj_r <= 1'b1;
      end else if (en) begin
         smp_r <= {smp_r[0], d};
         maj_r <= maj_nxt;
      end
   end

   property p_maj_high;
      @(posedge clk) disable iff (!rst_n) (en && d && (smp_r[0] || smp_r[1])) |=> maj_r;
   endproperty
   a_maj_high: assert property (p_maj_high) else $error("majority missed a high");

   property p_maj_low;
      @(posedge clk) disable iff (!rst_n) (en && !d && !(smp_r[0] && smp_r[1])) |=> !maj_r;
   endproperty
   a_maj_low: assert property (p_maj_low) else $error("majority missed a low");
endmodule

// ### logic/usr_baud_gen.sv
// dedicated 8-bit free-running baud generator with mode prescale
`timescale 1ns/1ps
module usr_baud_gen (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // configuration
   input  wire logic [7:0] div,
   input  wire logic       load,
   input  wire logic       sync,
   input  wire logic       high,
   // rate strobe
   output logic            tick_r
);
   logic [1:0] pre_r;
   logic [7:0] timer_r;

   // async low: 4(X+1) per 16x tick; async high: (X+1); sync: 2(X+1) per clock half
   wire [1:0] pre_lim = sync ? usr_pkg::PRE_SYNC :
                        (high ? usr_pkg::PRE_ASYNC_HI : usr_pkg::PRE_ASYNC_LO);
   wire       pre_wrap = (pre_r == pre_lim);
   wire       tmr_wrap = (timer_r == div);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r   <= 2'h0;
         timer_r <= 8'h00;
         tick_r  <= 1'b0;
      end else if (load) begin
         pre_r   <= 2'h0;
         timer_r <= 8'h00;
         tick_r  <= 1'b0;
      end else begin
         pre_r   <= pre_wrap ? 2'h0 : pre_r + 2'h1;
         timer_r <= !pre_wrap ? timer_r : (tmr_wrap ? 8'h00 : timer_r + 8'h01);
         tick_r  <= pre_wrap & tmr_wrap;
      end
   end

   property p_load_clears;
      @(posedge clk) disable iff (!rst_n) load |=> (timer_r == 8'h00) && !tick_r;
   endproperty
   a_load_clears: assert property (p_load_clears) else $error("divisor write did not clear timer");

   property p_wrap_ticks;
      @(posedge clk) disable iff (!rst_n) (pre_wrap && tmr_wrap && !load) |=> tick_r && timer_r == 8'h00;
   endproperty
   a_wrap_ticks: assert property (p_wrap_ticks) else $error("timer overflow gave no tick");
endmodule

// ### logic/usr_rx_ctrl.sv
// serial port receive control, status and baud generation
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// ----------------------------------------
// ----------------------------------------
module usr_rx_ctrl (
   // clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RST_N,
   // register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // serial pins
   input  wire logic       RX_PIN_IN,
   input  wire logic       CK_PIN_IN,
   output logic            CK_PIN_OUT,
   output logic            CK_PIN_OE_N,
   // interrupt
   output logic            IRQ
);
   // ----------------------------------------
   // register and receive state
   // ----------------------------------------
   logic       serial_port_enable_r;
   logic       nine_r;
   logic       single_receive_enable_r;
   logic       continuous_receive_enable_r;
   logic       framing_error_flag_r;
   logic       overrun_error_flag_r;
   logic       ninth_r;
   logic       csrc_r;
   logic       sync_r;
   logic       high_r;
   logic [7:0] div_r;
   logic [7:0] data_r;
   logic       full_r;
   logic [2:0] ist_r;
   logic [2:0] imask_r;
   usr_pkg::usr_rx_state_t state_r;
   usr_pkg::usr_rx_state_t state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [3:0] idx_r;
   logic [3:0] idx_nxt;
   logic [8:0] shf_r;
   logic [8:0] shf_nxt;
   logic       done;
   logic       stop_bad;
   logic [2:0] rx_s_r;
   logic [2:0] ck_s_r;
   logic       rx_lvl_r;
   logic       ck_lvl_r;
   logic       ck_lvl_d_r;
   logic       tick;
   logic       maj;
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire wr_rc    = WR && (ADDR == usr_pkg::OFF_RX_CTRL);
   wire wr_tc    = WR && (ADDR == usr_pkg::OFF_TX_CTRL);
   wire wr_div   = WR && (ADDR == usr_pkg::OFF_DIVISOR);
   wire wr_ist   = WR && (ADDR == usr_pkg::OFF_IRQ_STAT);
   wire wr_imask = WR && (ADDR == usr_pkg::OFF_IRQ_MASK);
   wire rd_data  = RD && (ADDR == usr_pkg::OFF_RX_DATA);
   wire master    = sync_r & csrc_r;
   // overrun halts reception until software toggles continuous receive
   wire rx_en     = serial_port_enable_r & !overrun_error_flag_r & (continuous_receive_enable_r | (master & single_receive_enable_r));
   wire master_run = rx_en & master;
   wire sync_edge = master ? (tick & !CK_PIN_OUT & master_run)
                           : (ck_lvl_r & !ck_lvl_d_r);
   wire [3:0] last_bit = nine_r ? usr_pkg::LAST_BIT_9 : usr_pkg::LAST_BIT_8;
   // ----------------------------------------
   // frame sequencing
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      idx_nxt   = idx_r;
      shf_nxt   = shf_r;
      done      = 1'b0;
      stop_bad  = 1'b0;
      if (!rx_en) begin
         state_nxt = usr_pkg::RX_IDLE;
      end else if (sync_r) begin
         if (state_r != usr_pkg::RX_DATA) begin
            state_nxt = usr_pkg::RX_DATA;
            idx_nxt   = 4'h0;
         end else if (sync_edge) begin
            shf_nxt = {rx_lvl_r, shf_r[8:1]};
            idx_nxt = idx_r + 4'h1;
            if (idx_r == last_bit) begin
               done    = 1'b1;
               idx_nxt = 4'h0;
            end
         end
      end else begin
         case (state_r)
            usr_pkg::RX_IDLE: begin
               if (!rx_lvl_r) begin
                  state_nxt = usr_pkg::RX_START;
                  cnt_nxt   = 4'h0;
               end
            end
            usr_pkg::RX_START: begin
               if (tick) begin
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == usr_pkg::SAMPLE_AT) begin
                     // a start bit that does not hold low is a glitch
                     state_nxt = maj ? usr_pkg::RX_IDLE : usr_pkg::RX_DATA;
                     idx_nxt   = 4'h0;
                  end
               end
            end
            usr_pkg::RX_DATA: begin
               if (tick) begin
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == usr_pkg::SAMPLE_AT) begin
                     shf_nxt = {maj, shf_r[8:1]};
                     idx_nxt = idx_r + 4'h1;
                     if (idx_r == last_bit) begin
                        state_nxt = usr_pkg::RX_STOP;
                     end
                  end
               end
            end
            usr_pkg::RX_STOP: begin
               if (tick) begin
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == usr_pkg::SAMPLE_AT) begin
                     done      = 1'b1;
                     stop_bad  = !maj;
                     state_nxt = usr_pkg::RX_IDLE;
                  end
               end
            end
            default: begin
               state_nxt = usr_pkg::RX_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------
   // events and next register values
   // ----------------------------------------
   wire load     = done & !full_r;
   wire ovr      = done & full_r & continuous_receive_enable_r;
   wire single_receive_enable_clr = done & master & !continuous_receive_enable_r;
   wire [2:0] ev = {ovr, load & stop_bad, load};
   wire       single_receive_enable_nxt  = single_receive_enable_clr ? 1'b0 : (wr_rc ? WDATA[usr_pkg::B_SINGLE_RECEIVE_ENABLE] : single_receive_enable_r);
   wire       overrun_error_flag_nxt  = (overrun_error_flag_r & continuous_receive_enable_r) | ovr;
   wire       framing_error_flag_nxt  = load ? stop_bad : framing_error_flag_r;
   wire       ninth_nxt = load ? (nine_r & shf_nxt[8]) : ninth_r;
   wire [7:0] data_nxt  = load ? (nine_r ? shf_nxt[7:0] : shf_nxt[8:1]) : data_r;
   wire       full_nxt  = load | (full_r & !rd_data);
   // a fresh event wins over a same-cycle write-one clear
   wire [2:0] ist_nxt   = ev | (ist_r & ~(wr_ist ? WDATA[2:0] : 3'h0));
   wire [7:0] rc_view = {serial_port_enable_r, nine_r, single_receive_enable_r, continuous_receive_enable_r, 1'b0, framing_error_flag_r, overrun_error_flag_r, ninth_r};
   wire [7:0] tc_view = {csrc_r, 2'b00, sync_r, 1'b0, high_r, 1'b1, 1'b0};
   wire [7:0] rd_mux  = (ADDR == usr_pkg::OFF_RX_CTRL)  ? rc_view :
                        (ADDR == usr_pkg::OFF_TX_CTRL)  ? tc_view :
                        (ADDR == usr_pkg::OFF_DIVISOR)  ? div_r :
                        (ADDR == usr_pkg::OFF_RX_DATA)  ? data_r :
                        (ADDR == usr_pkg::OFF_IRQ_STAT) ? {5'h00, ist_r} :
                        (ADDR == usr_pkg::OFF_IRQ_MASK) ? {5'h00, imask_r} : 8'h00;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rx_s_r     <= 3'h7;
         ck_s_r     <= 3'h0;
         rx_lvl_r   <= 1'b1;
         ck_lvl_r   <= 1'b0;
         ck_lvl_d_r <= 1'b0;
      end else begin
         rx_s_r     <= {rx_s_r[1:0], RX_PIN_IN};
         ck_s_r     <= {ck_s_r[1:0], CK_PIN_IN};
         rx_lvl_r   <= (rx_s_r[2] == rx_s_r[1]) ? rx_s_r[2] : rx_lvl_r;
         ck_lvl_r   <= (ck_s_r[2] == ck_s_r[1]) ? ck_s_r[2] : ck_lvl_r;
         ck_lvl_d_r <= ck_lvl_r;
      end
   end
   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         {serial_port_enable_r, nine_r, continuous_receive_enable_r} <= 3'h0;
         {csrc_r, sync_r, high_r} <= 3'h0;
         div_r   <= usr_pkg::RST_BYTE;
         imask_r <= 3'h0;
      end else begin
         if (wr_rc) begin
            serial_port_enable_r <= WDATA[usr_pkg::B_SERIAL_PORT_ENABLE];
            nine_r <= WDATA[usr_pkg::B_NINE];
            continuous_receive_enable_r <= WDATA[usr_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
         end
         if (wr_tc) begin
            csrc_r <= WDATA[usr_pkg::B_CSRC];
            sync_r <= WDATA[usr_pkg::B_SYNC];
            high_r <= WDATA[usr_pkg::B_HIGH];
         end
         if (wr_div) begin
            div_r <= WDATA;
         end
         if (wr_imask) begin
            imask_r <= WDATA[2:0];
         end
      end
   end
   // ----------------------------------------
   // status and received data
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         {single_receive_enable_r, framing_error_flag_r, overrun_error_flag_r, ninth_r, full_r} <= 5'h00;
         data_r <= usr_pkg::RST_BYTE;
         ist_r  <= 3'h0;
      end else begin
         single_receive_enable_r  <= single_receive_enable_nxt;
         framing_error_flag_r  <= framing_error_flag_nxt;
         overrun_error_flag_r  <= overrun_error_flag_nxt;
         ninth_r <= ninth_nxt;
         data_r  <= data_nxt;
         full_r  <= full_nxt;
         ist_r   <= ist_nxt;
      end
   end
   // ----------------------------------------
   // receive engine and outputs
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_r     <= usr_pkg::RX_IDLE;
         cnt_r       <= 4'h0;
         idx_r       <= 4'h0;
         shf_r       <= 9'h000;
         RDATA       <= 8'h00;
         IRQ         <= 1'b0;
         CK_PIN_OUT  <= 1'b0;
         CK_PIN_OE_N <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         idx_r       <= idx_nxt;
         shf_r       <= shf_nxt;
         RDATA       <= RD ? rd_mux : 8'h00;
         IRQ         <= |(ist_r & imask_r);
         CK_PIN_OUT  <= master_run & (tick ? !CK_PIN_OUT : CK_PIN_OUT);
         CK_PIN_OE_N <= !(serial_port_enable_r & master);
      end
   end
   // ----------------------------------------
   // baud generator and line sampler
   // ----------------------------------------
   usr_baud_gen u_baud (
      .clk    (CLK_SYS),
      .rst_n  (RST_N),
      .div    (div_r),
      .load   (wr_div),
      .sync   (sync_r),
      .high   (high_r),
      .tick_r (tick)
   );

   usr_maj_sampler u_smp (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .en    (tick),
      .d     (rx_lvl_r),
      .maj_r (maj)
   );
   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_single_done;
      done && master && !continuous_receive_enable_r;
   endsequence
   property p_single_clears;
      @(posedge CLK_SYS) disable iff (!RST_N) s_single_done |=> !single_receive_enable_r;
   endproperty
   a_single_clears: assert property (p_single_clears) else $error("single receive not cleared");
   property p_cont_overrides;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (done && continuous_receive_enable_r && !wr_rc) |=> single_receive_enable_r == $past(single_receive_enable_r);
   endproperty
   a_cont_overrides: assert property (p_cont_overrides) else $error("single receive disturbed");
   property p_overrun_clear;
      @(posedge CLK_SYS) disable iff (!RST_N) !continuous_receive_enable_r |=> !overrun_error_flag_r;
   endproperty
   a_overrun_clear: assert property (p_overrun_clear) else $error("overrun held without enable");
   property p_overrun_set;
      @(posedge CLK_SYS) disable iff (!RST_N) (done && full_r && continuous_receive_enable_r) |=> overrun_error_flag_r ##1 !rx_en;
   endproperty
   a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");
   property p_frame_update;
      @(posedge CLK_SYS) disable iff (!RST_N) load |=> framing_error_flag_r == $past(stop_bad) && full_r;
   endproperty
   a_frame_update: assert property (p_frame_update) else $error("framing flag not updated");
   property p_ninth_bit;
      @(posedge CLK_SYS) disable iff (!RST_N) (load && !nine_r) |=> !ninth_r;
   endproperty
   a_ninth_bit: assert property (p_ninth_bit) else $error("ninth bit set in 8-bit mode");
   property p_bit3_zero;
      @(posedge CLK_SYS) disable iff (!RST_N) (RD && ADDR == usr_pkg::OFF_RX_CTRL) |=> !RDATA[3];
   endproperty
   a_bit3_zero: assert property (p_bit3_zero) else $error("unimplemented bit reads one");
   property p_slave_no_drive;
      @(posedge CLK_SYS) disable iff (!RST_N) (sync_r && !csrc_r) |=> CK_PIN_OE_N && !CK_PIN_OUT;
   endproperty
   a_slave_no_drive: assert property (p_slave_no_drive) else $error("slave drives clock");
   property p_irq_level;
      @(posedge CLK_SYS) disable iff (!RST_N) (|(ist_r & imask_r)) |=> IRQ;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule

// ### sim/usr_line_model.sv
// serial line partner: async terminal and sync peripheral
`timescale 1ns/1ps
module usr_line_model (
   // clocks
   input  wire logic clk,
   input  wire logic ck_in,
   // line outputs
   output logic      line,
   output logic      ck_out
);
   initial begin
      line   = 1'b1;
      ck_out = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ----------------------------------------
   // frames
   // ----------------------------------------
   // async: start low, lsb first, stop; gl puts a three-clock spike mid bit 3
   // a single-clock spike would die in the pin synchroniser and never reach the vote
   task automatic send_async(input logic [8:0] d, input int nb, input int per,
                             input logic stop, input logic gl);
      line <= 1'b0;
      wait_clk(per);
      for (int i = 0; i < nb; i++) begin
         line <= d[i];
         if (gl && i == 3) begin
            wait_clk(per / 2);
            line <= ~d[i];
            wait_clk(3);
            line <= d[i];
            wait_clk(per - per / 2 - 3);
         end else begin
            wait_clk(per);
         end
      end
      line <= stop;
      wait_clk(per);
      line <= 1'b1;
      wait_clk(per);
   endtask
   // device clocks us: change data after falling edges only
   task automatic send_sync_m(input logic [7:0] d);
      line <= d[0];
      for (int i = 1; i < 8; i++) begin
         @(negedge ck_in);
         line <= d[i];
      end
      @(posedge ck_in);
      wait_clk(6);
      line <= ~d[7];
   endtask
   // we clock the device; clock stands low outside the frame
   task automatic send_sync_s(input logic [7:0] d, input int half);
      for (int i = 0; i < 8; i++) begin
         line <= d[i];
         wait_clk(half);
         ck_out <= 1'b1;
         wait_clk(half);
         ck_out <= 1'b0;
      end
      line <= ~d[7];
   endtask
endmodule

// ### sim/usr_rx_ctrl_tb.sv
// self-checking bench of the serial receive control block
`timescale 1ns/1ps
module usr_rx_ctrl_tb;
   localparam logic [7:0] A_CTL = usr_pkg::OFF_RX_CTRL;
   localparam logic [7:0] A_DAT = usr_pkg::OFF_RX_DATA;
   localparam logic [7:0] A_STA = usr_pkg::OFF_IRQ_STAT;
   localparam logic [7:0] A_MSK = usr_pkg::OFF_IRQ_MASK;
   localparam logic [7:0] A_TXC = usr_pkg::OFF_TX_CTRL;
   localparam logic [7:0] A_DIV = usr_pkg::OFF_DIVISOR;
   logic        CLK_SYS = 1'b0;
   logic        RST_N, WR, RD, RX_PIN_IN, CK_PIN_IN, CK_PIN_OUT, CK_PIN_OE_N, IRQ;
   logic [7:0]  ADDR, WDATA, RDATA, b0;
   logic [31:0] seed;
   int          fails, checks, dly;
   int          cycles = 0;
   realtime     t0;

   usr_rx_ctrl usr_rx_ctrl_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_PIN_IN(RX_PIN_IN),
      .CK_PIN_IN(CK_PIN_IN), .CK_PIN_OUT(CK_PIN_OUT), .CK_PIN_OE_N(CK_PIN_OE_N),
      .IRQ(IRQ));
   usr_line_model usr_line_model_i (.clk(CLK_SYS), .ck_in(CK_PIN_OUT),
      .line(RX_PIN_IN), .ck_out(CK_PIN_IN));

   always #20 CLK_SYS = ~CLK_SYS;
   // whole run needs about 15000 cycles
   always @(posedge CLK_SYS) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails = fails + 1;
         end_of_test();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic int bit_clks(input int x, input logic high);
      return high ? 16 * (x + 1) : 64 * (x + 1);
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK_SYS);
      WR    <= 1'b0;
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK_SYS);
      RD   <= 1'b0;
      #1 chk(what, {8'h00, exp}, {8'h00, RDATA});
   endtask
   task automatic irq_is(input logic exp);
      repeat (2) @(posedge CLK_SYS);
      #1 chk_bit("irq", exp, IRQ);
   endtask
   task automatic rx(input logic [8:0] d, input int nb, input int per, input logic stop,
                     input logic gl);
      usr_line_model_i.send_async(d, nb, per, stop, gl);
      repeat (8) @(posedge CLK_SYS);
   endtask
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      {RST_N, WR, RD, ADDR, WDATA} = '0;
      seed   = 32'h0001606a;
      fails  = 0;
      checks = 0;
      repeat (16) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      rd("rx_ctrl", A_CTL, 8'h00);
      @(posedge CLK_SYS);
      #1 chk("rdata_idle", 16'h0000, {8'h00, RDATA});
      rd("tx_ctrl", A_TXC, 8'h02);
      wr(8'h55, 8'hff);
      rd("unmapped", 8'h55, 8'h00);
      wr(A_CTL, 8'h0f);
      rd("rx_ctrl", A_CTL, 8'h00);
      chk_bit("ck_oe_n", 1'b1, CK_PIN_OE_N);
      $display("test reset done");
      wr(A_MSK, 8'h07);
      wr(A_DIV, 8'h02);
      wr(A_TXC, 8'h04);
      wr(A_CTL, 8'h90);
      for (int i = 0; i < 4; i++) begin
         b0 = rnd();
         rx({1'b0, b0}, 8, bit_clks(2, 1'b1), 1'b1, i[0]);
         #1 chk_bit("irq", 1'b1, IRQ);
         rd("rx_data", A_DAT, b0);
         rd("irq_stat", A_STA, 8'h01);
         wr(A_STA, 8'h01);
         irq_is(1'b0);
      end
      b0 = rnd();
      rx({1'b0, b0}, 8, 48, 1'b0, 1'b0);
      rd("rx_ctrl", A_CTL, 8'h94);
      rd("irq_stat", A_STA, 8'h03);
      wr(A_MSK, 8'h00);
      irq_is(1'b0);
      wr(A_MSK, 8'h07);
      irq_is(1'b1);
      rd("rx_data", A_DAT, b0);
      rd("rx_ctrl", A_CTL, 8'h94);
      wr(A_STA, 8'h07);
      b0 = rnd();
      rx({1'b0, b0}, 8, 48, 1'b1, 1'b0);
      rd("rx_ctrl", A_CTL, 8'h90);
      rd("rx_data", A_DAT, b0);
      wr(A_CTL, 8'hd0);
      for (int n = 0; n < 2; n++) begin
         b0 = rnd();
         rx({n[0], b0}, 9, 48, 1'b1, 1'b0);
         rd("rx_ctrl", A_CTL, 8'hd0 | {7'h00, n[0]});
         rd("rx_data", A_DAT, b0);
      end
      $display("test async high done");
      wr(A_TXC, 8'h00);
      wr(A_DIV, 8'h00);
      wr(A_CTL, 8'h90);
      wr(A_STA, 8'h07);
      b0 = rnd();
      rx({1'b0, b0}, 8, bit_clks(0, 1'b0), 1'b1, 1'b0);
      rx({1'b0, rnd()}, 8, 64, 1'b1, 1'b0);
      rd("rx_ctrl", A_CTL, 8'h92);
      rd("irq_stat", A_STA, 8'h05);
      rd("rx_data", A_DAT, b0);
      wr(A_CTL, 8'h80);
      rd("rx_ctrl", A_CTL, 8'h80);
      wr(A_CTL, 8'h90);
      b0 = rnd();
      rx({1'b0, b0}, 8, 64, 1'b1, 1'b0);
      rd("rx_data", A_DAT, b0);
      $display("test async low done");
      wr(A_DIV, 8'hff);
      rd("divisor", A_DIV, 8'hff);
      wr(A_TXC, 8'h94);
      wr(A_CTL, 8'ha0);
      b0 = rnd();
      fork
         usr_line_model_i.send_sync_m(b0);
         begin
            @(posedge CK_PIN_OUT);
            t0 = $realtime;
            chk_bit("ck_oe_n", 1'b0, CK_PIN_OE_N);
            @(posedge CK_PIN_OUT);
            chk("ck_period", 16'h0400, 16'(int'(($realtime - t0) / 40.0)));
            repeat (100) @(posedge CLK_SYS);
            wr(A_DIV, 8'hff);
            t0 = $realtime;
            @(negedge CK_PIN_OUT);
            dly = int'(($realtime - t0) / 40.0);
            chk_bit("reload", 1'b1, dly >= 505 && dly <= 516);
         end
      join
      repeat (8) @(posedge CLK_SYS);
      rd("rx_ctrl", A_CTL, 8'h80);
      rd("rx_data", A_DAT, b0);
      $display("test sync master done");
      wr(A_TXC, 8'h10);
      wr(A_CTL, 8'h90);
      irq_is(1'b1);
      chk_bit("ck_oe_n", 1'b1, CK_PIN_OE_N);
      b0 = rnd();
      usr_line_model_i.send_sync_s(b0, 8);
      repeat (8) @(posedge CLK_SYS);
      rd("rx_data", A_DAT, b0);
      $display("test sync slave done");
      end_of_test();
   end
endmodule
